// ### rtl/lfw_baseband.sv
// lf wake-up baseband: pulse filter, decoder, buffer, flags
// How it works
// (RQ1) accepts manchester telegrams near 3900 bit/s
// (RQ2) carrier-only mode flags wake on carrier
// (RQ3) telegram mode decodes and wakes on events
// (RQ4) sync, pattern, data events: own flag, mask
// (RQ5) receiver runs except during thermal shutdown
// (RQ6) tx low power: flag only, no resume
// (RQ7) all logic on one slow system clock
// (RQ8) first carrier pulse starts fixed inhibit window
// (RQ9) transmitter supplies enough carrier while inhibited
// (RQ10) hold counter reloads on carrier, counts down
// (RQ11) measure only after inhibit, before hold expiry
// (RQ12) software enables filter after setting threshold
// (RQ13) one or two patterns, 8 or 16 bits
// (RQ14) sync pattern is fixed in hardware
// (RQ15) sync carries deliberate manchester code violations
// (RQ16) bytes fill seven-entry ring, oldest overwritten
// (RQ17) optional wake on write to chosen index
// (RQ18) per-entry overwrite flag on unread rewrite
// (RQ19) per-entry pending flag for unread data
// (RQ20) code violation ends data, raises end-of-message
// (RQ21) reinit request bit clears itself when done
// (RQ22) reading an entry clears its two flags
`timescale 1ns/1ps
module lfw_baseband #(
  parameter int INHIBIT_CYCLES = lfw_pkg::INHIBIT_CYC,
  parameter int HOLD_CYCLES    = lfw_pkg::HOLD_CYC,
  parameter int HALF_CYCLES    = lfw_pkg::HALF_CYC
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // register port
  input  wire lfw_pkg::lfw_bus_req_s bus_req,
  output logic [7:0]                 rd_data,
  // analog front end
  input  wire lfw_pkg::lfw_pins_s    afe_in,
  // device state
  input  wire logic                  tx_low_power,
  input  wire logic                  thermal_shutdown,
  // wake and status
  output logic                       wake_req,
  output logic                       rx_active
);
  import lfw_pkg::*;

  // ==========================================================
  // register file state
  logic [7:0]            ctrl_ff, nxt_ctrl;     // mode, filter, reinit
  logic [7:0]            pfcfg_ff, nxt_pfcfg;   // width threshold
  logic [1:0]            pcfg_ff, nxt_pcfg;     // pattern count, length
  logic [3:0][7:0]       pat_ff, nxt_pat;       // p0l p0h p1l p1h
  logic [WK_W-1:0]       mask_ff, nxt_mask;     // 1 lets a flag wake
  logic [WK_W-1:0]       flag_ff, nxt_flag;     // sticky wake flags
  logic [3:0]            bwi_ff, nxt_bwi;       // enable and index
  logic [BUF_N-1:0]      pend_ff, nxt_pend;     // unread entries
  logic [BUF_N-1:0]      ovw_ff, nxt_ovw;       // rewritten unread
  logic [BUF_N-1:0][7:0] buf_ff, nxt_buf;       // ring storage
  logic [7:0]            rdata_ff, nxt_rdata;   // read answer
  logic                  wake_ff, nxt_wake;     // resume request
  logic                  act_ff, nxt_act;       // decoder powered

  // ==========================================================
  // decoder state
  lfw_state_e       st_ff, nxt_st;
  logic [CNT_W-1:0] chip_cnt_ff, nxt_chip_cnt;  // chip sample timer
  logic             dq_ff, nxt_dq;              // previous data level
  logic [15:0]      chip_sh_ff, nxt_chip_sh;    // recent chips
  logic             ph_ff, nxt_ph;              // second chip of a bit
  logic [15:0]      bit_sh_ff, nxt_bit_sh;      // decoded bits
  logic [4:0]       bit_cnt_ff, nxt_bit_cnt;
  logic [2:0]       widx_ff, nxt_widx;          // ring write index

  // ==========================================================
  // pulse filter state
  logic             started_ff, nxt_started;    // first pulse seen
  logic             armed_ff, nxt_armed;        // hold not expired
  logic             done_ff, nxt_done;          // one detect per init
  logic             cq_ff, nxt_cq;              // previous carrier
  logic [CNT_W-1:0] inh_ff, nxt_inh;
  logic [CNT_W-1:0] hold_ff, nxt_hold;
  logic [CNT_W-1:0] wid_ff, nxt_wid;

  // ==========================================================
  // cross-group signals
  logic [1:0]      pins_q;      // filtered carrier, data
  logic            carr, din;
  logic [WK_W-1:0] ev_set;      // events from decoder and filter
  logic            byte_stb;    // byte ready for the ring
  logic [7:0]      byte_val;
  logic            reinit;      // reinit acting this cycle
  logic [1:0]      mode;
  logic            chip_stb;
  logic            bit_ok;
  logic            bit_val, carr_ev;
  logic [15:0]     want0, want1, got;

  // buffer address test
  function automatic logic is_buf(input logic [4:0] a);
    is_buf = (a >= A_BUF0) && (a <= A_BUF6);
  endfunction : is_buf

  // ==========================================================
  // pin synchroniser
  lfw_pin_sync #(.N(2)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     ({afe_in.carrier, afe_in.data}),
    .q       (pins_q)
  );
  assign carr   = pins_q[1];
  assign din    = pins_q[0];
  assign mode   = ctrl_ff[CTRL_MODE +: 2];
  assign reinit = ctrl_ff[CTRL_INIT];

  // ==========================================================
  // pulse filter: inhibit, hold, width measure
  always_comb begin
    nxt_started   = started_ff;
    nxt_armed     = armed_ff;
    nxt_done      = done_ff;
    nxt_inh       = inh_ff;
    nxt_hold      = hold_ff;
    nxt_wid       = wid_ff;
    nxt_cq        = carr;
    carr_ev       = 1'b0;
    if (thermal_shutdown || reinit || mode != MODE_CARR) begin // RQ5
      // receiver off: restart on next pulse
      nxt_started = 1'b0;
      nxt_armed   = 1'b0;
      nxt_done    = 1'b0;
      nxt_inh     = '0;
      nxt_hold    = '0;
      nxt_wid     = '0;
    end else if (!ctrl_ff[CTRL_PFEN]) begin
      // analog path only: any carrier rise wakes
      if (carr && !cq_ff) begin
        carr_ev = 1'b1; // RQ2
      end
    end else if (!started_ff) begin
      // first pulse opens the inhibit window
      if (carr) begin
        nxt_started = 1'b1;
        nxt_armed   = 1'b1;
        nxt_inh     = CNT_W'(INHIBIT_CYCLES - 1); // RQ8
        nxt_hold    = CNT_W'(HOLD_CYCLES - 1);
      end
    end else begin
      // inhibit runs regardless of carrier; agc settles meanwhile
      nxt_inh = (inh_ff != '0) ? inh_ff - 1'b1 : '0; // RQ8
      if (carr) begin
        nxt_hold = CNT_W'(HOLD_CYCLES - 1); // RQ10
      end else if (hold_ff != '0) begin
        nxt_hold = hold_ff - 1'b1; // RQ10
      end else begin
        nxt_armed = 1'b0; // RQ11
      end
      // width counts only in a live, settled pulse
      if (!carr) begin
        nxt_wid = '0;
      end else if (inh_ff == '0 && armed_ff && !done_ff) begin // RQ11
        nxt_wid = wid_ff + 1'b1;
        if (wid_ff >= (CNT_W'(pfcfg_ff) << PW_SHIFT)) begin
          carr_ev  = 1'b1;
          nxt_done = 1'b1;
        end
      end
    end
  end

  // pulse filter registers
  always_ff @(posedge clk_sys) begin // RQ7
    if (rst) begin
      started_ff <= 1'b0;
      armed_ff   <= 1'b0;
      done_ff    <= 1'b0;
      cq_ff      <= 1'b0;
      inh_ff     <= '0;
      hold_ff    <= '0;
      wid_ff     <= '0;
    end else begin
      started_ff <= nxt_started;
      armed_ff   <= nxt_armed;
      done_ff    <= nxt_done;
      cq_ff      <= nxt_cq;
      inh_ff     <= nxt_inh;
      hold_ff    <= nxt_hold;
      wid_ff     <= nxt_wid;
    end
  end

  // ==========================================================
  // decoder: chip timing, sync, pattern, data
  always_comb begin
    nxt_st       = st_ff;
    nxt_chip_cnt = chip_cnt_ff;
    nxt_dq       = din;
    nxt_chip_sh  = chip_sh_ff;
    nxt_ph       = ph_ff;
    nxt_bit_sh   = bit_sh_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_widx     = widx_ff;
    byte_stb     = 1'b0;
    byte_val     = bit_sh_ff[7:0];
    bit_ok       = 1'b0;
    bit_val      = 1'b0;
    got          = '0;
    ev_set       = WK_W'(carr_ev) << WK_CARR;
    // edges re-centre the sampler mid-chip
    chip_stb = (din == dq_ff) && (chip_cnt_ff == '0); // RQ1
    if (din != dq_ff) begin
      nxt_chip_cnt = CNT_W'(HALF_CYCLES / 2);
    end else if (chip_cnt_ff == '0) begin
      nxt_chip_cnt = CNT_W'(HALF_CYCLES - 1);
    end else begin
      nxt_chip_cnt = chip_cnt_ff - 1'b1;
    end
    if (chip_stb) begin
      nxt_chip_sh = {chip_sh_ff[14:0], din};
    end
    // chip pair 10 is one, 01 is zero, else a violation
    bit_ok  = chip_stb && ph_ff && (chip_sh_ff[0] != din);
    bit_val = chip_sh_ff[0];
    want0   = pcfg_ff[CFG_LEN16] ? {pat_ff[1], pat_ff[0]} : {8'h00, pat_ff[0]};
    want1   = pcfg_ff[CFG_LEN16] ? {pat_ff[3], pat_ff[2]} : {8'h00, pat_ff[2]};
    if (thermal_shutdown || reinit || mode != MODE_TEL) begin // RQ5
      nxt_st      = ST_IDLE;
      nxt_ph      = 1'b0;
      nxt_bit_cnt = '0;
      nxt_widx    = '0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          nxt_st = ST_SYNC; // RQ3
        end
        ST_SYNC: begin
          // fixed chip string, not a software pattern
          if (chip_stb && nxt_chip_sh == SYNC_CHIPS) begin // RQ14 RQ15
            ev_set[WK_SYNC] = 1'b1; // RQ4
            nxt_st          = ST_PAT;
            nxt_ph          = 1'b0;
            nxt_bit_cnt     = '0;
          end
        end
        ST_PAT, ST_DATA: begin
          if (chip_stb) begin
            nxt_ph = !ph_ff;
          end
          if (chip_stb && ph_ff && !bit_ok) begin
            // violation ends the telegram
            nxt_st = ST_SYNC;
            if (st_ff == ST_DATA) begin
              ev_set[WK_EOM] = 1'b1; // RQ20
              nxt_st = mask_ff[WK_EOM] ? ST_WAIT : ST_SYNC; // RQ20
            end
          end else if (bit_ok) begin
            nxt_bit_sh  = {bit_sh_ff[14:0], bit_val};
            nxt_bit_cnt = bit_cnt_ff + 1'b1;
            got = pcfg_ff[CFG_LEN16] ? nxt_bit_sh : {8'h00, nxt_bit_sh[7:0]};
            if (st_ff == ST_PAT) begin
              if (nxt_bit_cnt == (pcfg_ff[CFG_LEN16] ? 5'h10 : 5'h08)) begin
                nxt_bit_cnt = '0;
                nxt_st      = ST_SYNC;
                if (got == want0 || (pcfg_ff[CFG_TWO] && got == want1)) begin // RQ13
                  ev_set[WK_PAT] = 1'b1; // RQ4
                  nxt_st         = ST_DATA;
                end
              end
            end else if (nxt_bit_cnt == 5'h08) begin
              // full byte into the ring
              byte_stb    = 1'b1; // RQ16
              byte_val    = nxt_bit_sh[7:0];
              nxt_bit_cnt = '0;
              nxt_widx    = (widx_ff == 3'(BUF_N - 1)) ? 3'h0 : widx_ff + 1'b1; // RQ16
              if (bwi_ff[BWI_EN] && bwi_ff[2:0] == widx_ff) begin
                ev_set[WK_BUF] = 1'b1; // RQ17
              end
            end
          end
        end
        ST_WAIT: begin
          // parked until software asks for reinit
          nxt_st = ST_WAIT;
        end
        default: begin
          nxt_st = ST_IDLE;
        end
      endcase
    end
  end

  // decoder registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff       <= ST_IDLE;
      chip_cnt_ff <= '0;
      dq_ff       <= 1'b0;
      chip_sh_ff  <= '0;
      ph_ff       <= 1'b0;
      bit_sh_ff   <= '0;
      bit_cnt_ff  <= '0;
      widx_ff     <= '0;
    end else begin
      st_ff       <= nxt_st;
      chip_cnt_ff <= nxt_chip_cnt;
      dq_ff       <= nxt_dq;
      chip_sh_ff  <= nxt_chip_sh;
      ph_ff       <= nxt_ph;
      bit_sh_ff   <= nxt_bit_sh;
      bit_cnt_ff  <= nxt_bit_cnt;
      widx_ff     <= nxt_widx;
    end
  end

  // ==========================================================
  // register file: writes, reads, flags, ring storage
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_pfcfg = pfcfg_ff;
    nxt_pcfg  = pcfg_ff;
    nxt_pat   = pat_ff;
    nxt_mask  = mask_ff;
    nxt_bwi   = bwi_ff;
    nxt_buf   = buf_ff;
    nxt_rdata = 8'h00;
    nxt_flag  = flag_ff;
    nxt_pend  = pend_ff;
    nxt_ovw   = ovw_ff;
    // reinit lasts one cycle; a fresh write wins
    nxt_ctrl[CTRL_INIT] = 1'b0; // RQ21
    if (bus_req.wr) begin
      case (bus_req.addr)
        A_CTRL:  nxt_ctrl  = bus_req.wdata;
        A_PFCFG: nxt_pfcfg = bus_req.wdata; // RQ12
        A_PCFG:  nxt_pcfg  = bus_req.wdata[1:0];
        A_P0L:   nxt_pat[0] = bus_req.wdata;
        A_P0H:   nxt_pat[1] = bus_req.wdata;
        A_P1L:   nxt_pat[2] = bus_req.wdata;
        A_P1H:   nxt_pat[3] = bus_req.wdata;
        A_MASK:  nxt_mask  = bus_req.wdata[WK_W-1:0];
        A_FLAG:  nxt_flag  = flag_ff & ~bus_req.wdata[WK_W-1:0];
        A_BWI:   nxt_bwi   = bus_req.wdata[3:0];
        default: nxt_ctrl  = nxt_ctrl; // others ignored
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        A_CTRL:  nxt_rdata = ctrl_ff;
        A_PFCFG: nxt_rdata = pfcfg_ff;
        A_PCFG:  nxt_rdata = {6'h00, pcfg_ff};
        A_P0L:   nxt_rdata = pat_ff[0];
        A_P0H:   nxt_rdata = pat_ff[1];
        A_P1L:   nxt_rdata = pat_ff[2];
        A_P1H:   nxt_rdata = pat_ff[3];
        A_MASK:  nxt_rdata = {3'h0, mask_ff};
        A_FLAG:  nxt_rdata = {3'h0, flag_ff};
        A_BWI:   nxt_rdata = {4'h0, bwi_ff};
        A_PEND:  nxt_rdata = {1'b0, pend_ff}; // RQ19
        A_OVW:   nxt_rdata = {1'b0, ovw_ff}; // RQ18
        A_STAT:  nxt_rdata = {2'h0, widx_ff, st_ff};
        default: nxt_rdata = 8'h00;
      endcase
      if (is_buf(bus_req.addr)) begin
        // reading consumes the entry
        nxt_rdata = buf_ff[3'(bus_req.addr - A_BUF0)];
        nxt_pend[3'(bus_req.addr - A_BUF0)] = 1'b0; // RQ22
        nxt_ovw[3'(bus_req.addr - A_BUF0)]  = 1'b0; // RQ22
      end
    end
    // hardware sets win over software clears
    if (byte_stb) begin
      nxt_buf[widx_ff]  = byte_val; // RQ16
      nxt_pend[widx_ff] = 1'b1; // RQ19
      nxt_ovw[widx_ff]  = ovw_ff[widx_ff] | pend_ff[widx_ff]; // RQ18
    end
    nxt_flag = nxt_flag | ev_set; // RQ4
    // in tx low power events are only recorded
    nxt_wake = (|(flag_ff & mask_ff)) && !tx_low_power; // RQ6
    nxt_act  = (mode == MODE_TEL) && !thermal_shutdown; // RQ3
  end

  // register file registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_ff  <= RST_BYTE;
      pfcfg_ff <= RST_BYTE;
      pcfg_ff  <= 2'h0;
      pat_ff   <= '0;
      mask_ff  <= RST_WK;
      flag_ff  <= RST_WK;
      bwi_ff   <= 4'h0;
      pend_ff  <= '0;
      ovw_ff   <= '0;
      buf_ff   <= '0;
      rdata_ff <= RST_BYTE;
      wake_ff  <= 1'b0;
      act_ff   <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      pfcfg_ff <= nxt_pfcfg;
      pcfg_ff  <= nxt_pcfg;
      pat_ff   <= nxt_pat;
      mask_ff  <= nxt_mask;
      flag_ff  <= nxt_flag;
      bwi_ff   <= nxt_bwi;
      pend_ff  <= nxt_pend;
      ovw_ff   <= nxt_ovw;
      buf_ff   <= nxt_buf;
      rdata_ff <= nxt_rdata;
      wake_ff  <= nxt_wake;
      act_ff   <= nxt_act;
    end
  end

  // outputs straight from flip-flops
  assign rd_data   = rdata_ff;
  assign wake_req  = wake_ff;
  assign rx_active = act_ff;
endmodule : lfw_baseband

// ### rtl/lfw_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module lfw_pin_sync #(
  parameter int N = 2
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // raw pins and filtered levels
  input  wire logic [N-1:0] pin,
  output logic      [N-1:0] q
);
  // ==========
  // stages per pin
  logic [N-1:0] s1_ff;      // metastable stage, read only by s2
  logic [N-1:0] s2_ff;
  logic [N-1:0] s3_ff;
  logic [N-1:0] q_ff;       // accepted level
  logic [N-1:0] nxt_q;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      // accept once stages two and three agree
      always_comb begin
        nxt_q[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : q_ff[g];
      end
      // register stages
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          s1_ff[g] <= 1'b0;
          s2_ff[g] <= 1'b0;
          s3_ff[g] <= 1'b0;
          q_ff[g]  <= 1'b0;
        end else begin
          s1_ff[g] <= pin[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          q_ff[g]  <= nxt_q[g];
        end
      end
    end
  endgenerate

  assign q = q_ff;
endmodule : lfw_pin_sync

// ### rtl/lfw_pkg.sv
// package: constants, states and types of the baseband
package lfw_pkg;
  // ==========
  // clock and timing
  localparam int CLK_HZ      = 50_000_000;   // clk_sys rate
  localparam int CLK_NS      = 20;           // clk_sys period
  localparam int INHIBIT_NS  = 3_740_000;    // agc settle window, least time
  localparam int INHIBIT_CYC = (INHIBIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_NS     = 2_000_000;    // gap allowed between pulses
  localparam int HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIT_RATE    = 3900;         // manchester bit rate
  localparam int HALF_CYC    = CLK_HZ / (2 * BIT_RATE); // one chip
  localparam int CNT_W       = 18;           // width of all timers
  localparam int PW_SHIFT    = 8;            // width threshold unit 2^8 cycles

  // ==========
  // register offsets
  localparam int ADDR_W = 5;
  localparam logic [4:0] A_CTRL  = 5'h00;    // mode, filter enable, reinit
  localparam logic [4:0] A_PFCFG = 5'h01;    // pulse_filter_config threshold
  localparam logic [4:0] A_PCFG  = 5'h02;    // pattern_count_length_config
  localparam logic [4:0] A_P0L   = 5'h03;    // pattern0_low_byte
  localparam logic [4:0] A_P0H   = 5'h04;    // pattern0_high_byte
  localparam logic [4:0] A_P1L   = 5'h05;    // pattern1_low_byte
  localparam logic [4:0] A_P1H   = 5'h06;    // pattern1_high_byte
  localparam logic [4:0] A_MASK  = 5'h07;    // wake enable mask
  localparam logic [4:0] A_FLAG  = 5'h08;    // wake_flag_register, w1c
  localparam logic [4:0] A_BWI   = 5'h09;    // buffer_wake_index
  localparam logic [4:0] A_PEND  = 5'h0a;    // buffer_pending_flags
  localparam logic [4:0] A_OVW   = 5'h0b;    // buffer_overwrite_flags
  localparam logic [4:0] A_STAT  = 5'h0c;    // receiver state
  localparam logic [4:0] A_BUF0  = 5'h10;    // rx_buffer_entry_first
  localparam logic [4:0] A_BUF6  = 5'h16;    // rx_buffer_entry_last

  // ==========
  // field positions
  localparam int CTRL_MODE = 0;              // two bits
  localparam int CTRL_PFEN = 2;              // pulse_filter_enable
  localparam int CTRL_INIT = 3;              // fsm_reinit_request
  localparam int CFG_TWO   = 0;              // two patterns in use
  localparam int CFG_LEN16 = 1;              // patterns are 16 bits
  localparam int BWI_EN    = 3;              // buffer wake enable
  localparam int WK_CARR   = 0;              // carrier detected
  localparam int WK_SYNC   = 1;              // sync match
  localparam int WK_PAT    = 2;              // pattern match
  localparam int WK_BUF    = 3;              // byte at chosen index
  localparam int WK_EOM    = 4;              // end of message
  localparam int WK_W      = 5;

  // ==========
  // modes, reset values, fixed patterns
  localparam logic [1:0]  MODE_OFF  = 2'h0;
  localparam logic [1:0]  MODE_CARR = 2'h1;
  localparam logic [1:0]  MODE_TEL  = 2'h2;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [4:0]  RST_WK    = 5'h00;
  localparam logic [15:0] SYNC_CHIPS = 16'he38d; // four runs of three chips, then 1101
  localparam int BUF_N = 7;

  // ==========
  // receiver states, gray along idle-sync-pattern-data-wait
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SYNC = 3'b001,
    ST_PAT  = 3'b011,
    ST_DATA = 3'b010,
    ST_WAIT = 3'b110
  } lfw_state_e;

  // register port request
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lfw_bus_req_s;

  // front end outputs
  typedef struct packed {
    logic carrier;
    logic data;
  } lfw_pins_s;
endpackage : lfw_pkg

// ### testbench/lfw_afe_model.sv
// partner: analog front end carrying a remote lf transmitter
`timescale 1ns/1ps
module lfw_afe_model #(
  parameter int HALF = 8                  // cycles of one chip
) (
  // clock
  input  wire logic          clk_sys,
  // front end outputs
  output lfw_pkg::lfw_pins_s pins
);
  import lfw_pkg::*;
  // no carrier at power-up
  initial pins = '0;
  // one chip with carrier present
  task automatic chip(input logic v);
    pins.carrier <= 1'b1;
    pins.data    <= v;
    repeat (HALF) @(posedge clk_sys);
  endtask : chip
  // manchester bits msb first: 10 is one, 01 is zero
  task automatic bits(input logic [15:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      chip(b[i]);
      chip(!b[i]);
    end
  endtask : bits
  // preamble, sync, pattern, eight bytes, violation
  task automatic frame(input logic [15:0] pat, input int plen, input logic [63:0] d);
    bits(16'h000f, 4);
    for (int i = 15; i >= 0; i--) chip(SYNC_CHIPS[i]);
    bits(pat, plen);
    for (int k = 0; k < 8; k++) bits({8'h00, d[8*k +: 8]}, 8);
    chip(1'b0);
    chip(1'b0);
    // released slicer shows the inverse
    pins.carrier <= 1'b0;
    pins.data    <= !pins.data;
    @(posedge clk_sys);
  endtask : frame
  // carrier burst then gap; long bursts cover agc settling
  task automatic pulse(input int on, input int off);
    pins.carrier <= 1'b1;
    repeat (on) @(posedge clk_sys);
    pins.carrier <= 1'b0;
    repeat (off) @(posedge clk_sys);
  endtask : pulse
endmodule : lfw_afe_model

// ### testbench/lfw_props.sv
// checker: port properties of the lf wake-up baseband
`timescale 1ns/1ps
module lfw_props (
  // clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst,
  // watched ports
  input wire lfw_pkg::lfw_bus_req_s bus_req,
  input wire logic [7:0]            rd_data,
  input wire logic                  tx_low_power,
  input wire logic                  thermal_shutdown,
  input wire logic                  wake_req,
  input wire logic                  rx_active
);
  import lfw_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========
  // helpers
  logic       ctrl_wr;   // control register write
  logic [4:0] mask_ff;   // mask shadow
  logic [4:0] nxt_mask;
  assign ctrl_wr = bus_req.wr && bus_req.addr == A_CTRL;
  // fed from the bus so a stuck mask shows
  always_comb begin
    nxt_mask = mask_ff;
    if (rst) nxt_mask = 5'h00;
    else if (bus_req.wr && bus_req.addr == A_MASK) nxt_mask = bus_req.wdata[4:0];
  end
  always_ff @(posedge clk_sys) mask_ff <= nxt_mask;
  // ==========
  // multi-step bus sequences
  sequence s_tel_on;
    ctrl_wr && bus_req.wdata[1:0] == MODE_TEL ##1 !ctrl_wr && !thermal_shutdown;
  endsequence
  sequence s_tel_off;
    ctrl_wr && bus_req.wdata[1:0] != MODE_TEL ##1 !ctrl_wr;
  endsequence
  sequence s_init_rd;
    ctrl_wr && bus_req.wdata[CTRL_INIT] ##2 bus_req.rd && bus_req.addr == A_CTRL;
  endsequence
  sequence s_pend_rd;
    bus_req.rd && bus_req.addr == A_BUF0 ##2 bus_req.rd && bus_req.addr == A_PEND;
  endsequence
  // ==========
  // properties
  a_rd_quiet: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data outside its cycle");
  a_tx_hold: assert property (tx_low_power |=> !wake_req)
    else $error("wake raised in tx low power");
  a_thermal_off: assert property (thermal_shutdown |=> !rx_active)
    else $error("receiver active in shutdown");
  a_tel_on: assert property (s_tel_on |=> rx_active)
    else $error("telegram mode not active");
  a_tel_off: assert property (s_tel_off |=> !rx_active)
    else $error("active outside telegram mode");
  a_mask_read: assert property (bus_req.rd && bus_req.addr == A_MASK |=> rd_data[4:0] == mask_ff)
    else $error("mask readback differs");
  a_init_clear: assert property (s_init_rd |=> !rd_data[CTRL_INIT])
    else $error("reinit bit did not clear");
  a_pend_clear: assert property (s_pend_rd |=> !rd_data[0])
    else $error("pending kept after entry read");
endmodule : lfw_props
bind lfw_baseband lfw_props u_props (
  .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
  .tx_low_power(tx_low_power), .thermal_shutdown(thermal_shutdown),
  .wake_req(wake_req), .rx_active(rx_active));

// ### testbench/tb_lfw_baseband.sv
// testbench: register, telegram and carrier scenarios of the baseband
`timescale 1ns/1ps
module tb_lfw_baseband;
  import lfw_pkg::*;
  // ==========
  // signals
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  lfw_bus_req_s bus_req = '0;
  logic [7:0]   rd_data;
  lfw_pins_s    afe_in;
  logic         tx_low_power = 1'b0;
  logic         thermal_shutdown = 1'b0;
  logic         wake_req;
  logic         rx_active;
  int           n_mismatch = 0;
  int           n_checks = 0;
  logic [7:0]   got;     // last masked read
  logic [63:0]  d;       // eight random data bytes
  logic [31:0]  p;       // both random patterns
  always #10 clk_sys = ~clk_sys;
  // short timers keep the run brief
  lfw_baseband #(.INHIBIT_CYCLES(50), .HOLD_CYCLES(40), .HALF_CYCLES(8)) DUT (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .afe_in(afe_in), .tx_low_power(tx_low_power),
    .thermal_shutdown(thermal_shutdown), .wake_req(wake_req), .rx_active(rx_active));
  lfw_afe_model #(.HALF(8)) u_afe (.clk_sys(clk_sys), .pins(afe_in));
  // ==========
  // helpers
  function automatic logic [15:0] pat_of(input int c, input logic [31:0] v);
    return c[CFG_TWO] ? v[31:16] : v[15:0];
  endfunction : pat_of
  task automatic check(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus_req <= {a, v, 2'b10};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : wr
  // data stand only in the cycle after rd
  task automatic rd(input logic [4:0] a, input logic [7:0] m, e, input bit c);
    @(posedge clk_sys);
    bus_req <= {a, 8'h00, 2'b01};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 got = rd_data & m;
    if (c) check(got, e);
  endtask : rd
  // bounded wait on one flag bit
  task automatic poll(input int b);
    for (int i = 0; i < 200; i++) begin
      rd(A_FLAG, 8'(1 << b), 8'h00, 1'b0);
      if (got !== 8'h00) return;
    end
    n_mismatch++;
    $display("[FAIL] %0t flag %0d never set", $time, b);
    end_of_test();
  endtask : poll
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  // ==========
  // main sequence
  initial begin
    void'($urandom(70619));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // all addresses read zero after reset
    for (int a = 0; a < 32; a++) rd(5'(a), 8'hff, 8'h00, 1'b1);
    wr(A_MASK, 8'h1f);
    rd(A_MASK, 8'hff, 8'h1f, 1'b1);
    wr(A_BWI, 8'h09);
    // every pattern count and length
    for (int c = 0; c < 4; c++) begin
      p = $urandom();
      d = {$urandom(), $urandom()};
      wr(A_CTRL, 8'h0a);
      wr(A_FLAG, 8'h1f);
      wr(A_PCFG, 8'(c));
      for (int r = 0; r < 4; r++) wr(5'(A_P0L + r), p[8*r +: 8]);
      u_afe.frame(pat_of(c, p), c[CFG_LEN16] ? 16 : 8, d);
      poll(WK_EOM);
      rd(A_FLAG, 8'h1e, 8'h1e, 1'b1);
      rd(A_OVW, 8'h7f, 8'h01, 1'b1);
      rd(A_PEND, 8'h7f, 8'h7f, 1'b1);
      rd(A_BUF0, 8'hff, d[63:56], 1'b1);
      rd(A_PEND, 8'h7f, 8'h7e, 1'b1);
      for (int i = 1; i < BUF_N; i++) rd(5'(A_BUF0 + i), 8'hff, d[8*i +: 8], 1'b1);
      rd(A_PEND, 8'h7f, 8'h00, 1'b1);
    end
    check(8'(wake_req), 8'h01);
    @(posedge clk_sys) tx_low_power <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check(8'(wake_req), 8'h00);
    rd(A_FLAG, 8'h1e, 8'h1e, 1'b1);
    @(posedge clk_sys) tx_low_power <= 1'b0;
    wr(A_CTRL, 8'h0a);
    rd(A_CTRL, 8'h0f, 8'h02, 1'b1);
    // carrier rows: plain, hold expired, measured after inhibit
    wr(A_PFCFG, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wr(A_CTRL, k == 0 ? 8'h09 : 8'h0d);
      wr(A_FLAG, 8'h1f);
      u_afe.pulse(10, k == 1 ? 100 : 20);
      u_afe.pulse(k == 0 ? 10 : 400, 20);
      rd(A_FLAG, 8'h01, k == 1 ? 8'h00 : 8'h01, 1'b1);
    end
    wr(A_CTRL, 8'h02);
    repeat (2) @(posedge clk_sys);
    #1 check(8'(rx_active), 8'h01);
    @(posedge clk_sys) thermal_shutdown <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 check(8'(rx_active), 8'h00);
    end_of_test();
  end
endmodule : tb_lfw_baseband
